// ### hdl/idp_port.sv
// Digital input sampler and output driver with power-up high impedance
`timescale 1ns/1ps
module idp_port
   import idp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [DIV_W-1:0] sample_div,
   input wire logic [NUM_IN-1:0] din_pin,
   output logic [NUM_IN-1:0] sample_data,
   output logic sample_valid,
   input wire logic out_write,
   input wire logic [NUM_OUT-1:0] out_data,
   input wire logic prepare,
   input wire logic [NUM_GROUPS-1:0] driver_type_select,
   output logic [NUM_OUT-1:0] high_side_on,
   output logic [NUM_OUT-1:0] low_side_on,
   output logic outputs_enabled
);
   logic [NUM_IN-1:0] din_meta_reg;
   logic [NUM_IN-1:0] din_sync_reg;
   logic [NUM_GROUPS-1:0] odrn_meta_reg;
   logic [NUM_GROUPS-1:0] odrn_sync_reg;
   logic [NUM_IN-1:0] catch_reg;
   logic [NUM_IN-1:0] catch_next;
   logic [DIV_W-1:0] cnt_reg;
   logic [DIV_W-1:0] div_eff;
   logic tick;
   idp_state_e state_reg;
   logic [NUM_OUT-1:0] level_reg;
   logic [NUM_OUT-1:0] level_next;
   logic load;
   logic [NUM_OUT-1:0] hs_next;
   logic [NUM_OUT-1:0] ls_next;
   logic [NUM_OUT-1:0] out_data_d;
   logic [DIV_W-1:0] gap_cnt_reg;

   // Clamp rate so it never exceeds the fastest allowed
   assign div_eff = (sample_div < MIN_DIV_V) ? MIN_DIV_V : sample_div;
   assign tick = (cnt_reg >= div_eff - 16'h0001);

   always_ff @(posedge clk) begin
      din_meta_reg <= din_pin;
      din_sync_reg <= din_meta_reg;
      odrn_meta_reg <= driver_type_select;
      odrn_sync_reg <= odrn_meta_reg;
   end

   always_ff @(posedge clk) begin
      if (rst || tick) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   // Latch any HIGH; sample reports latch OR current level
   assign catch_next = catch_reg | din_sync_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         catch_reg <= '0;
         sample_data <= '0;
         sample_valid <= 1'b0;
      end else begin
         sample_valid <= tick;
         if (tick) begin
            sample_data <= catch_next;
            catch_reg <= '0;
         end else begin
            catch_reg <= catch_next;
         end
      end
   end

   // Prepare without a value loads LOW
   assign load = out_write || prepare;
   assign level_next = out_write ? out_data : {NUM_GROUPS{OUT_INIT}};

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= ST_OFF;
         level_reg <= '0;
      end else if (load) begin
         state_reg <= ST_ON;
         level_reg <= level_next;
      end
   end

   // Strap decode, shared by the drivers and their checks
   function automatic logic is_totem(logic strap);
      return (strap == 1'(ODRN_TOTEM));
   endfunction : is_totem

   // Switch control from the same new level, so no HIGH passes first
   genvar g;
   generate
      for (g = 0; g < NUM_GROUPS; g++) begin : g_grp
         logic [PORT_W-1:0] lv;
         logic on;
         logic totem;
         assign on = load || (state_reg == ST_ON);
         assign lv = load ? level_next[g*PORT_W +: PORT_W]
                          : level_reg[g*PORT_W +: PORT_W];
         assign totem = is_totem(odrn_sync_reg[g]);
         assign hs_next[g*PORT_W +: PORT_W] =
            (on && totem) ? lv : '0;
         assign ls_next[g*PORT_W +: PORT_W] = on ? ~lv : '0;
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         high_side_on <= '0;
         low_side_on <= '0;
         outputs_enabled <= 1'b0;
      end else begin
         high_side_on <= hs_next;
         low_side_on <= ls_next;
         outputs_enabled <= load || (state_reg == ST_ON);
      end
   end

   // Registered copy of the written level for the checks below
   always_ff @(posedge clk) begin
      out_data_d <= out_data;
   end

   // Cycles since the last sample, for the spacing check
   always_ff @(posedge clk) begin
      if (rst) begin
         gap_cnt_reg <= MIN_DIV_V;
      end else if (sample_valid) begin
         gap_cnt_reg <= 16'h0001;
      end else if (gap_cnt_reg != 16'hffff) begin
         gap_cnt_reg <= gap_cnt_reg + 16'h0001;
      end
   end

   chk_off_before_write: assert property (
      @(posedge clk) disable iff (rst)
      (state_reg == ST_OFF && !$past(load))
      |-> (high_side_on == '0 && low_side_on == '0))
      else $error("outputs driven before first write");
   chk_off_disabled: assert property (
      @(posedge clk) disable iff (rst)
      !outputs_enabled |-> (high_side_on == '0 && low_side_on == '0))
      else $error("switch on while outputs disabled");
   chk_first_low: assert property (
      @(posedge clk) disable iff (rst)
      (state_reg == ST_OFF && out_write)
      |=> ((high_side_on & ~out_data_d) == '0))
      else $error("high side on for a low first write");
   chk_no_overlap: assert property (
      @(posedge clk) disable iff (rst)
      (high_side_on & low_side_on) == '0)
      else $error("both switches on");
   chk_enable_write: assert property (
      @(posedge clk) disable iff (rst)
      load |=> outputs_enabled)
      else $error("write did not enable outputs");
   chk_enable_hold: assert property (
      @(posedge clk) disable iff (rst)
      outputs_enabled |=> outputs_enabled)
      else $error("outputs disabled without reset");
   chk_level_hold: assert property (
      @(posedge clk) disable iff (rst)
      !load |=> $stable(low_side_on))
      else $error("low side changed without a write");
   chk_prepare_low: assert property (
      @(posedge clk) disable iff (rst)
      (prepare && !out_write)
      |=> (high_side_on == '0 && low_side_on == '1))
      else $error("prepare did not drive low");

   // Per group: the switches follow a write in the strapped mode
   generate
      for (g = 0; g < NUM_GROUPS; g++) begin : g_chk
         sequence s_write_totem;
            out_write && is_totem(odrn_sync_reg[g]);
         endsequence
         sequence s_write_open;
            out_write && !is_totem(odrn_sync_reg[g]);
         endsequence
         chk_totem_level: assert property (
            @(posedge clk) disable iff (rst)
            s_write_totem |=> high_side_on[g*PORT_W +: PORT_W]
               == out_data_d[g*PORT_W +: PORT_W])
            else $error("push-pull high side does not follow write");
         chk_open_high: assert property (
            @(posedge clk) disable iff (rst)
            s_write_open |=> high_side_on[g*PORT_W +: PORT_W] == '0)
            else $error("open-drain high side switched on");
         chk_low_follow: assert property (
            @(posedge clk) disable iff (rst)
            out_write |=> low_side_on[g*PORT_W +: PORT_W]
               == ~out_data_d[g*PORT_W +: PORT_W])
            else $error("low side does not follow write");
      end
   endgenerate

   generate
      for (g = 0; g < NUM_IN; g++) begin : g_catch
         chk_catch_pulse: assert property (
            @(posedge clk) disable iff (rst)
            (din_sync_reg[g] && !tick) |=> catch_reg[g])
            else $error("input pulse not latched");
         chk_catch_keep: assert property (
            @(posedge clk) disable iff (rst)
            (catch_reg[g] && !tick) |=> catch_reg[g])
            else $error("latched pulse lost before sample");
      end
   endgenerate

   chk_catch_clear: assert property (
      @(posedge clk) disable iff (rst)
      tick |=> catch_reg == '0)
      else $error("latch not cleared at sample");
   chk_sample_or: assert property (
      @(posedge clk) disable iff (rst)
      tick |=> sample_data == $past(catch_next))
      else $error("sample not latch OR level");
   chk_rate_min: assert property (
      @(posedge clk) disable iff (rst)
      sample_valid |=> !sample_valid)
      else $error("samples too close");
   chk_sample_spacing: assert property (
      @(posedge clk) disable iff (rst)
      sample_valid |-> gap_cnt_reg >= MIN_DIV_V)
      else $error("sample interval shorter than the fastest rate");
endmodule : idp_port

// ### hdl/idp_pkg.sv
// Constants for the isolated digital I/O port
package idp_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int NUM_IN = 16;
   localparam int NUM_OUT = 16;
   localparam int PORT_W = 8;
   localparam int NUM_IN_PORTS = NUM_IN / PORT_W;
   localparam int NUM_GROUPS = NUM_OUT / PORT_W;
   localparam int MAX_RATE_HZ = 10000;
   // Shortest sample interval in cycles (least time, rounded up)
   localparam int MIN_DIV = (CLK_HZ + MAX_RATE_HZ - 1) / MAX_RATE_HZ;
   localparam int DIV_W = 16;
   localparam logic [DIV_W-1:0] MIN_DIV_V = DIV_W'(MIN_DIV);
   localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'(MIN_DIV);
   localparam logic [PORT_W-1:0] OUT_INIT = 8'h00;
   // Driver switching time and the resulting least spacing of writes
   localparam int SWITCH_NS = 165000;
   localparam int SWITCH_CYC = (SWITCH_NS * 20 + 999) / 1000;
   localparam int ODRN_TOTEM = 0;
   typedef enum {ST_OFF, ST_ON} idp_state_e;
endpackage : idp_pkg

// ### bench/idp_load.sv
// Load model: switches on the inputs, pulled-up relay loads on the outputs
`timescale 1ns/1ps
module idp_load
   import idp_pkg::*;
(
   input wire logic [NUM_OUT-1:0] low_side_on,
   input wire logic [NUM_IN-1:0] sw_level,
   output logic [NUM_IN-1:0] din_pin,
   output logic [NUM_OUT-1:0] pin_level
);
   // A released output floats up to the load supply
   assign pin_level = ~low_side_on;
   assign din_pin = sw_level;
endmodule : idp_load

// ### bench/tb_isolated_digital_io_port.sv
// Testbench for the digital I/O port
`timescale 1ns/1ps
module tb_isolated_digital_io_port;
   import idp_pkg::*;
   logic clk = 0, rst = 1, out_write = 0, prepare = 0, sample_valid, en;
   logic [DIV_W-1:0] sample_div = '0;
   logic [NUM_IN-1:0] sw = '0, din_pin, sample_data, acc = '0;
   logic [NUM_IN-1:0] p1 = '0, p2 = '0;
   logic [NUM_OUT-1:0] out_data = '0, hs, ls, lvl, e;
   logic [NUM_GROUPS-1:0] dts = '0;
   int n_errors = 0, checks = 0, cyc = 0, last = 0, exp_div = MIN_DIV;
   always #25 clk = ~clk;
   idp_port i_idp_port(.clk(clk), .rst(rst), .sample_div(sample_div),
      .din_pin(din_pin), .sample_data(sample_data),
      .sample_valid(sample_valid), .out_write(out_write),
      .out_data(out_data), .prepare(prepare), .driver_type_select(dts),
      .high_side_on(hs), .low_side_on(ls), .outputs_enabled(en));
   idp_load i_idp_load(.low_side_on(ls), .sw_level(sw), .din_pin(din_pin),
      .pin_level(lvl));
   task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic tally_and_finish();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic wr(logic p, logic [15:0] d);
      repeat (SWITCH_CYC) @(posedge clk);
      @(posedge clk);
      #2 prepare = p;
      out_write = !p;
      out_data = d;
      @(posedge clk);
      #2 prepare = 0;
      out_write = 0;
      e = d & {{8{~dts[1]}}, {8{~dts[0]}}};
      cmp("high_side", e, hs);
      cmp("low_side", ~d, ls);
      cmp("pin_level", d, lvl);
      cmp("enabled", 16'h0001, {15'h0, en});
   endtask : wr
   // Reference sampler: OR of pins over each interval, pins seen 2 late
   always @(posedge clk) begin
      cyc <= cyc + 1;
      p1 <= sw;
      p2 <= p1;
      if (rst) begin
         last <= 0;
         acc <= '0;
      end else if (sample_valid) begin
         cmp("sample", acc, sample_data);
         if (last != 0) cmp("interval", 16'(exp_div), 16'(cyc - last));
         last <= cyc;
         acc <= p2;
      end else acc <= acc | p2;
      if (cyc > 60000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      void'($urandom(32'h02d80b8a));
      repeat (6) @(posedge clk);
      #2 rst = 0;
      cmp("high_side", '0, hs);
      cmp("low_side", '0, ls);
      repeat (4) begin
         @(posedge clk iff sample_valid);
         repeat ($urandom_range(1999, 1)) @(posedge clk);
         #2 sw = 16'($urandom);
         @(posedge clk);
         #2 sw = '0;
      end
      @(posedge clk iff sample_valid);
      wr(1'b1, 16'h0000);
      for (int m = 0; m < 4; m++) begin
         #2 dts = 2'(m);
         repeat (4) @(posedge clk);
         wr(1'b0, 16'($urandom));
      end
      #2 rst = 1;
      dts = '0;
      sample_div = 16'(MIN_DIV + $urandom_range(499, 1));
      exp_div = int'(sample_div);
      repeat (4) @(posedge clk);
      #2 rst = 0;
      cmp("enabled", 16'h0000, {15'h0, en});
      cmp("low_side", '0, ls);
      wr(1'b0, 16'h0000);
      repeat (3) @(posedge clk iff sample_valid);
      tally_and_finish();
   end
endmodule : tb_isolated_digital_io_port
